// >>> rtl/cisq_core_irq_seq.sv
// Interrupt sequencer of an 8-bit core with APB register access
//
// The APB register port and the register addresses were chosen for this implementation.
`default_nettype none
module cisq_core_irq_seq (
	input wire logic i_clk, // 200 MHz clock
	input wire logic i_rst, // Synchronous reset, active high
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB direction
	input wire logic [7:0] i_paddr, // APB byte address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic o_pready, // APB ready
	output logic [31:0] o_prdata, // APB read data
	output logic o_pslverr, // APB error on unmapped address
	input wire cisq_pkg::cisq_evt_t i_evt, // Synchronous event pulses
	input wire logic i_ext_pin, // Asynchronous external interrupt pin
	input wire logic i_ret_instr, // Return instruction executes, one pulse
	input wire logic [12:0] i_pc, // Current program counter
	output cisq_pkg::cisq_core_req_t o_core, // Requests to the program sequencer
	output logic [1:0] o_quarter, // Current quarter phase, 0 is Q1
	output logic o_irq // Level interrupt to the system
);
	localparam int INSTR_CYC = int'(cisq_pkg::QUARTER_CYC * cisq_pkg::QUARTERS);
	localparam int LAT_MIN = INSTR_CYC + 1;
	localparam int LAT_MAX = 2 * INSTR_CYC;
	localparam int LAT_AMAX = 3 * INSTR_CYC;
	localparam int QC = int'(cisq_pkg::QUARTER_CYC);

	// Address match, used by both read and write decode
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction

	logic [7:0] div_reg;
	logic [1:0] phase_reg;
	logic q_tick, cyc_start;
	logic pin_s1, pin_s2, pin_s3, pin_lvl_reg, edge_hit, ext_hold_reg, ext_window;
	logic pin_armed_reg;
	logic [7:0] ctrl_reg, ctrl_next, opt_reg, pfa_reg, pfa_next, pfb_reg, pfb_next;
	logic [7:0] pea_reg, peb_reg;
	logic [2:0] ist_reg, ist_next, imsk_reg, ist_set;
	logic pready_reg, acc, wr_en, mapped, pend_next, take;
	logic [31:0] rdata;
	cisq_pkg::cisq_seq_t seq_reg;
	cisq_pkg::cisq_core_req_t core_reg;

	// ********************************************************
	// Quarter phase divider
	// ********************************************************
	// One clock-enable pulse per quarter; Q1 starts each instruction cycle
	assign q_tick = (div_reg == 8'(QC - 1));
	assign cyc_start = q_tick && (phase_reg == 2'h3);
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			div_reg <= 8'h00;
			phase_reg <= 2'h0;
		end else if (q_tick) begin
			div_reg <= 8'h00;
			phase_reg <= phase_reg + 2'h1;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	// ********************************************************
	// External pin: synchroniser, edge select, Q4-Q1 window
	// ********************************************************
	// Level counts only once second and third stages agree; the stages keep
	// sampling through reset so the pin's level is settled at release
	always_ff @(posedge i_clk) begin
		pin_s1 <= i_ext_pin;
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
	end

	// First settled level after reset is the idle level, never an edge, so a
	// pin already high at release cannot set the flag
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pin_armed_reg <= 1'b0;
			pin_lvl_reg <= 1'b0;
		end else if (pin_s2 == pin_s3) begin
			pin_armed_reg <= 1'b1;
			pin_lvl_reg <= pin_s3;
		end
	end

	assign edge_hit = pin_armed_reg && (pin_s2 == pin_s3) && (pin_s3 != pin_lvl_reg)
		&& (pin_s3 == opt_reg[cisq_pkg::B_EDGE_SEL]);
	// Edges seen in Q2/Q3 wait for Q4, which adds no latency since entry is only checked at the end of Q4
	assign ext_window = (phase_reg == 2'h3) || (phase_reg == 2'h0);
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ext_hold_reg <= 1'b0;
		end else begin
			ext_hold_reg <= (ext_hold_reg || edge_hit) && !ext_window;
		end
	end

	// ********************************************************
	// APB slave
	// ********************************************************
	// One wait state: ready is registered so the read data is too
	assign acc = i_psel && i_penable && !pready_reg;
	assign wr_en = i_psel && i_penable && pready_reg && i_pwrite;
	assign mapped = hit(i_paddr, cisq_pkg::OFF_CTRL) || hit(i_paddr, cisq_pkg::OFF_OPT)
		|| hit(i_paddr, cisq_pkg::OFF_PFA) || hit(i_paddr, cisq_pkg::OFF_PFB)
		|| hit(i_paddr, cisq_pkg::OFF_PEA) || hit(i_paddr, cisq_pkg::OFF_PEB)
		|| hit(i_paddr, cisq_pkg::OFF_SEQ) || hit(i_paddr, cisq_pkg::OFF_IST)
		|| hit(i_paddr, cisq_pkg::OFF_IMSK);

	// Read mux; unmapped reads return zero
	always_comb begin
		rdata = 32'h0000_0000;
		unique case (1'b1)
			hit(i_paddr, cisq_pkg::OFF_CTRL): rdata[7:0] = ctrl_reg;
			hit(i_paddr, cisq_pkg::OFF_OPT): rdata[7:0] = opt_reg;
			hit(i_paddr, cisq_pkg::OFF_PFA): rdata[7:0] = pfa_reg;
			hit(i_paddr, cisq_pkg::OFF_PFB): rdata[7:0] = pfb_reg;
			hit(i_paddr, cisq_pkg::OFF_PEA): rdata[7:0] = pea_reg;
			hit(i_paddr, cisq_pkg::OFF_PEB): rdata[7:0] = peb_reg;
			hit(i_paddr, cisq_pkg::OFF_SEQ): rdata[4:0] = {phase_reg, pend_next, seq_reg};
			hit(i_paddr, cisq_pkg::OFF_IST): rdata[2:0] = ist_reg;
			hit(i_paddr, cisq_pkg::OFF_IMSK): rdata[2:0] = imsk_reg;
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pready_reg <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			pready_reg <= acc;
			o_prdata <= acc ? rdata : 32'h0000_0000;
			o_pslverr <= acc && !mapped;
		end
	end
	assign o_pready = pready_reg;

	// ********************************************************
	// Flags and enables
	// ********************************************************
	// Hardware sets win over a software write in the same cycle
	always_comb begin
		ctrl_next = (wr_en && hit(i_paddr, cisq_pkg::OFF_CTRL)) ? i_pwdata[7:0] : ctrl_reg;
		pfa_next = (wr_en && hit(i_paddr, cisq_pkg::OFF_PFA)) ? i_pwdata[7:0] : pfa_reg;
		pfb_next = (wr_en && hit(i_paddr, cisq_pkg::OFF_PFB)) ? i_pwdata[7:0] : pfb_reg;
		ctrl_next[cisq_pkg::B_TMR_IF] = ctrl_next[cisq_pkg::B_TMR_IF] || i_evt.tmr_ovf;
		ctrl_next[cisq_pkg::B_CHG_IF] = ctrl_next[cisq_pkg::B_CHG_IF] || i_evt.port_chg;
		ctrl_next[cisq_pkg::B_EXT_IF] = ctrl_next[cisq_pkg::B_EXT_IF]
			|| ((ext_hold_reg || edge_hit) && ext_window);
		pfa_next = pfa_next | i_evt.periph_a;
		pfb_next = pfb_next | i_evt.periph_b;
		// Entry clears the global enable, return sets it
		if (take) begin
			ctrl_next[cisq_pkg::B_GIE] = 1'b0;
		end else if (i_ret_instr) begin
			ctrl_next[cisq_pkg::B_GIE] = 1'b1;
		end
	end

	// Every reset clears enables, so nothing redirects until software allows it
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_reg <= cisq_pkg::CTRL_RST;
			pfa_reg <= cisq_pkg::PREG_RST;
			pfb_reg <= cisq_pkg::PREG_RST;
		end else begin
			ctrl_reg <= ctrl_next;
			pfa_reg <= pfa_next;
			pfb_reg <= pfb_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			opt_reg <= cisq_pkg::OPT_RST;
			pea_reg <= cisq_pkg::PREG_RST;
			peb_reg <= cisq_pkg::PREG_RST;
			imsk_reg <= cisq_pkg::IST_RST;
		end else if (wr_en) begin
			if (hit(i_paddr, cisq_pkg::OFF_OPT)) opt_reg <= i_pwdata[7:0];
			if (hit(i_paddr, cisq_pkg::OFF_PEA)) pea_reg <= i_pwdata[7:0];
			if (hit(i_paddr, cisq_pkg::OFF_PEB)) peb_reg <= i_pwdata[7:0];
			if (hit(i_paddr, cisq_pkg::OFF_IMSK)) imsk_reg <= i_pwdata[2:0];
		end
	end

	// Any enabled flag requests; all share one vector with no priority
	assign pend_next = (ctrl_next[cisq_pkg::B_TMR_IE] && ctrl_next[cisq_pkg::B_TMR_IF])
		|| (ctrl_next[cisq_pkg::B_EXT_IE] && ctrl_next[cisq_pkg::B_EXT_IF])
		|| (ctrl_next[cisq_pkg::B_CHG_IE] && ctrl_next[cisq_pkg::B_CHG_IF])
		|| (ctrl_reg[cisq_pkg::B_PERIPHERAL_GROUP_IRQ_ENABLE] && |((pfa_next & pea_reg) | (pfb_next & peb_reg)));
	assign take = cyc_start && (seq_reg == cisq_pkg::SEQ_IDLE)
		&& ctrl_reg[cisq_pkg::B_GIE] && pend_next;

	// ********************************************************
	// Entry sequence
	// ********************************************************
	// Flush in the cycle after the event, push and vector load in the next
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			seq_reg <= cisq_pkg::SEQ_IDLE;
		end else if (cyc_start) begin
			unique case (seq_reg)
				cisq_pkg::SEQ_IDLE: if (take) seq_reg <= cisq_pkg::SEQ_FLUSH;
				cisq_pkg::SEQ_FLUSH: seq_reg <= cisq_pkg::SEQ_VECTOR;
				cisq_pkg::SEQ_VECTOR: seq_reg <= cisq_pkg::SEQ_IDLE;
				default: seq_reg <= cisq_pkg::SEQ_IDLE;
			endcase
		end
	end

	// Only the return PC goes to the stack; W, status, pointer, latch untouched
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			core_reg <= '0;
		end else begin
			core_reg.flush <= take;
			core_reg.push <= cyc_start && (seq_reg == cisq_pkg::SEQ_FLUSH);
			core_reg.load <= cyc_start && (seq_reg == cisq_pkg::SEQ_FLUSH);
			core_reg.push_pc <= i_pc;
			core_reg.load_pc <= cisq_pkg::VECTOR_ADDR;
			core_reg.pop <= i_ret_instr;
		end
	end
	assign o_core = core_reg;

	// ********************************************************
	// System interrupt: sticky status, write one to clear
	// ********************************************************
	assign ist_set = {edge_hit, core_reg.pop, core_reg.load};
	always_comb begin
		ist_next = ist_reg;
		if (wr_en && hit(i_paddr, cisq_pkg::OFF_IST)) ist_next = ist_reg & ~i_pwdata[2:0];
		ist_next = ist_next | ist_set;
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ist_reg <= cisq_pkg::IST_RST;
			o_irq <= 1'b0;
			o_quarter <= 2'h0;
		end else begin
			ist_reg <= ist_next;
			o_irq <= |(ist_next & imsk_reg);
			o_quarter <= phase_reg;
		end
	end

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_flush;
		o_core.flush && !ctrl_reg[cisq_pkg::B_GIE];
	endsequence
	sequence s_vector;
		o_core.push && o_core.load && (o_core.load_pc == cisq_pkg::VECTOR_ADDR);
	endsequence

	a_reset_clears_enables:
	assert property ($fell(i_rst) |-> !ctrl_reg[cisq_pkg::B_GIE] && pea_reg == 8'h00
		&& !o_core.flush)
		else $error("Enables not clear after reset");
	a_take_needs_enable:
	assert property ($rose(o_core.flush) |-> $past(ctrl_reg[cisq_pkg::B_GIE]))
		else $error("Interrupt taken without global enable");
	a_flag_always_sets:
	assert property (i_evt.tmr_ovf || i_evt.port_chg
		|=> (ctrl_reg[cisq_pkg::B_TMR_IF] || !$past(i_evt.tmr_ovf))
		&& (ctrl_reg[cisq_pkg::B_CHG_IF] || !$past(i_evt.port_chg)))
		else $error("Event flag not set");
	a_periph_flags_set:
	assert property ((i_evt.periph_a | i_evt.periph_b) != 8'h00
		|=> (pfa_reg & $past(i_evt.periph_a)) == $past(i_evt.periph_a)
		&& (pfb_reg & $past(i_evt.periph_b)) == $past(i_evt.periph_b))
		else $error("Peripheral flag not set");
	a_entry_steps:
	assert property (s_flush |-> ##[INSTR_CYC:INSTR_CYC] s_vector)
		else $error("Entry sequence out of step");
	a_gie_blocks_take:
	assert property (cyc_start && !ctrl_reg[cisq_pkg::B_GIE]
		&& seq_reg == cisq_pkg::SEQ_IDLE |=> seq_reg == cisq_pkg::SEQ_IDLE)
		else $error("Redirect while global enable clear");
	a_pending_taken:
	assert property (cyc_start && ctrl_reg[cisq_pkg::B_GIE] && pend_next
		&& seq_reg == cisq_pkg::SEQ_IDLE |=> o_core.flush)
		else $error("Pending interrupt not taken");
	a_return_sets_gie:
	assert property (i_ret_instr && !take |=> o_core.pop && ctrl_reg[cisq_pkg::B_GIE])
		else $error("Return did not pop and enable");
	a_sync_latency:
	assert property (i_evt.tmr_ovf && ctrl_reg[cisq_pkg::B_TMR_IE]
		&& ctrl_reg[cisq_pkg::B_GIE] && seq_reg == cisq_pkg::SEQ_IDLE && !i_psel
		|-> ##[LAT_MIN:LAT_MAX] o_core.load)
		else $error("Synchronous latency wrong");
	a_async_latency:
	assert property (edge_hit && ctrl_reg[cisq_pkg::B_EXT_IE]
		&& ctrl_reg[cisq_pkg::B_GIE] && seq_reg == cisq_pkg::SEQ_IDLE && !i_psel
		|-> ##[LAT_MIN:LAT_AMAX] o_core.load)
		else $error("Asynchronous latency wrong");
	a_ext_flag_window:
	assert property ($rose(ctrl_reg[cisq_pkg::B_EXT_IF]) && !$past(wr_en)
		|-> $past(phase_reg) == 2'h3 || $past(phase_reg) == 2'h0)
		else $error("Pin flag set outside Q4-Q1");
	a_ext_edge_sel:
	assert property (edge_hit |-> pin_s3 == opt_reg[cisq_pkg::B_EDGE_SEL]
		##[1:9] ctrl_reg[cisq_pkg::B_EXT_IF])
		else $error("Pin edge polarity wrong");
	a_push_saves_pc:
	assert property (o_core.push |-> o_core.push_pc == $past(i_pc)
		&& o_core.load_pc == cisq_pkg::VECTOR_ADDR)
		else $error("Pushed PC wrong");
	// Flags only ever fall through a software write
	a_flags_sticky:
	assert property (!wr_en
		|=> (ctrl_reg[cisq_pkg::B_TMR_IF] || !$past(ctrl_reg[cisq_pkg::B_TMR_IF]))
		&& (ctrl_reg[cisq_pkg::B_EXT_IF] || !$past(ctrl_reg[cisq_pkg::B_EXT_IF]))
		&& (ctrl_reg[cisq_pkg::B_CHG_IF] || !$past(ctrl_reg[cisq_pkg::B_CHG_IF]))
		&& ((pfa_reg & $past(pfa_reg)) == $past(pfa_reg)))
		else $error("Flag cleared without a write");
	a_take_at_q1:
	assert property ($rose(o_core.flush) |-> $past(cyc_start))
		else $error("Entry not on an instruction boundary");
	a_status_sticky:
	assert property (!(wr_en && hit(i_paddr, cisq_pkg::OFF_IST))
		|=> (ist_reg & $past(ist_reg)) == $past(ist_reg))
		else $error("Status bit lost without a clear");
endmodule
`default_nettype wire

// >>> rtl/cisq_pkg.sv
// Constants and carrier types shared by the core interrupt sequencer
`default_nettype none
package cisq_pkg;
	// ********************************************************
	// Timing
	// ********************************************************
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned QUARTER_NS = 20;
	localparam int unsigned QUARTER_CYC = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned QUARTERS = 4;
	localparam logic [12:0] VECTOR_ADDR = 13'h0004;
	// ********************************************************
	// Register byte offsets
	// ********************************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_OPT = 8'h04;
	localparam logic [7:0] OFF_PFA = 8'h08;
	localparam logic [7:0] OFF_PFB = 8'h0c;
	localparam logic [7:0] OFF_PEA = 8'h10;
	localparam logic [7:0] OFF_PEB = 8'h14;
	localparam logic [7:0] OFF_SEQ = 8'h18;
	localparam logic [7:0] OFF_IST = 8'h1c;
	localparam logic [7:0] OFF_IMSK = 8'h20;
	// ********************************************************
	// Field positions and reset values
	// ********************************************************
	localparam int unsigned B_GIE = 7;
	localparam int unsigned B_PERIPHERAL_GROUP_IRQ_ENABLE = 6;
	localparam int unsigned B_TMR_IE = 5;
	localparam int unsigned B_EXT_IE = 4;
	localparam int unsigned B_CHG_IE = 3;
	localparam int unsigned B_TMR_IF = 2;
	localparam int unsigned B_EXT_IF = 1;
	localparam int unsigned B_CHG_IF = 0;
	localparam int unsigned B_EDGE_SEL = 0;
	localparam int unsigned B_ST_ENTRY = 0;
	localparam int unsigned B_ST_RETURN = 1;
	localparam int unsigned B_ST_EDGE = 2;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] OPT_RST = 8'h01;
	localparam logic [7:0] PREG_RST = 8'h00;
	localparam logic [2:0] IST_RST = 3'h0;
	// ********************************************************
	// Types
	// ********************************************************
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_FLUSH, SEQ_VECTOR} cisq_seq_t;
	typedef struct packed {
		logic flush;
		logic push;
		logic [12:0] push_pc;
		logic load;
		logic [12:0] load_pc;
		logic pop;
	} cisq_core_req_t;
	typedef struct packed {
		logic tmr_ovf;
		logic port_chg;
		logic [7:0] periph_a;
		logic [7:0] periph_b;
	} cisq_evt_t;
endpackage
`default_nettype wire

// >>> dv/cisq_core_model.sv
// Behavioural program sequencer on the far side of the interrupt sequencer
`default_nettype none
module cisq_core_model (
	input wire logic i_clk, // Clock
	input wire logic i_rst, // Synchronous reset, active high
	input wire cisq_pkg::cisq_core_req_t i_core, // Requests from the sequencer
	output logic [12:0] o_pc // Program counter seen by the sequencer
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [12:0] stack_reg [8];
	logic [2:0] sp_reg;
	logic [3:0] tick_reg;
	logic hold_reg;
	// One instruction per 16 clocks; a flushed fetch costs a slot, so a late
	// vector load would show up as a stale pushed address
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_pc <= 13'h0100;
			sp_reg <= 3'h0;
			tick_reg <= 4'h0;
			hold_reg <= 1'b0;
		end else begin
			tick_reg <= tick_reg + 4'h1;
			if (i_core.flush) begin
				hold_reg <= 1'b1;
			end else if (tick_reg == 4'hf) begin
				hold_reg <= 1'b0;
			end
			if (i_core.load) begin
				o_pc <= i_core.load_pc;
				stack_reg[sp_reg] <= i_core.push_pc;
				sp_reg <= sp_reg + 3'h1;
			end else if (i_core.pop) begin
				o_pc <= stack_reg[sp_reg - 3'h1];
				sp_reg <= sp_reg - 3'h1;
			end else if (tick_reg == 4'hf && !hold_reg) begin
				o_pc <= o_pc + 13'h1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the core interrupt sequencer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, psel, penable, pwrite, pin, ret, pready, pslverr, irq, err, pin_q, push_ok;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] quarter;
	logic [12:0] pc, pc_q;
	cisq_pkg::cisq_evt_t evt;
	cisq_pkg::cisq_core_req_t core;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	int loads = 0;
	int ev_at, pin_at, ret_at, flush_at, load_at, pop_at;
	cisq_core_irq_seq i_dut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .i_evt(evt), .i_ext_pin(pin),
		.i_ret_instr(ret), .i_pc(pc), .o_core(core), .o_quarter(quarter), .o_irq(irq));
	cisq_core_model i_core_model (.i_clk(clk), .i_rst(rst), .i_core(core), .o_pc(pc));
	// Clock at 200 MHz
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Timestamps of causes and answers, all taken at the same edge
	always @(posedge clk) begin
		cyc <= cyc + 1;
		pc_q <= pc;
		pin_q <= pin;
		if (evt !== '0) ev_at <= cyc;
		if (pin !== pin_q) pin_at <= cyc;
		if (ret === 1'b1) ret_at <= cyc;
		if (core.flush === 1'b1) flush_at <= cyc;
		if (core.pop === 1'b1) pop_at <= cyc;
		if (core.load === 1'b1) begin
			load_at <= cyc;
			loads <= loads + 1;
			push_ok <= core.push === 1'b1 && core.push_pc === pc_q
				&& core.load_pc === cisq_pkg::VECTOR_ADDR;
		end
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Idle cycle after release keeps psel from being assigned twice in one step
	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (pready !== 1'b1) chk("apb ready", 32'h1, 32'h0);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	task automatic pulse(input cisq_pkg::cisq_evt_t e);
		evt <= e;
		@(posedge clk);
		evt <= '0;
	endtask
	task automatic quiet(input int n);
		int n0;
		n0 = loads;
		repeat (n) @(posedge clk);
		chk("no vector load", n0, loads);
	endtask
	task automatic wait_load(input int lim);
		int n0;
		int n;
		n0 = loads;
		n = 0;
		while (loads == n0 && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk("vector load seen", n0 + 1, loads);
	endtask
	task automatic retire();
		ret <= 1'b1;
		@(posedge clk);
		ret <= 1'b0;
		repeat (2) @(posedge clk);
		chk("pop one clock after return", ret_at + 1, pop_at);
	endtask
	task automatic wr_irq(input logic [7:0] a, input logic [31:0] d, input logic exp);
		wr(a, d);
		repeat (2) @(posedge clk);
		chk("irq level", {31'h0, exp}, {31'h0, irq});
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		rchk("ctrl reset", cisq_pkg::OFF_CTRL, {24'h0, cisq_pkg::CTRL_RST});
		rchk("option reset", cisq_pkg::OFF_OPT, {24'h0, cisq_pkg::OPT_RST});
		rchk("enable a reset", cisq_pkg::OFF_PEA, 32'h0);
		rchk("unmapped data", 8'h40, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
	endtask
	// Each quarter lasts its clock count and the phase steps by one
	task automatic t_quarter();
		logic [1:0] q0;
		int n;
		q0 = quarter;
		n = 0;
		while (quarter == q0 && n < 8) begin
			@(posedge clk);
			n++;
		end
		repeat (4) begin
			q0 = quarter;
			n = 0;
			while (quarter == q0 && n < 8) begin
				@(posedge clk);
				n++;
			end
			chk("quarter length", cisq_pkg::QUARTER_CYC, n);
			chk("quarter step", {30'h0, q0 + 2'h1}, {30'h0, quarter});
		end
	endtask
	task automatic t_flags();
		pulse(18'h30101);
		quiet(64);
		rchk("ctrl flags", cisq_pkg::OFF_CTRL, 32'h05);
		rchk("flags a", cisq_pkg::OFF_PFA, 32'h01);
		rchk("flags b", cisq_pkg::OFF_PFB, 32'h01);
		wr(cisq_pkg::OFF_CTRL, 32'h0);
		wr(cisq_pkg::OFF_PFA, 32'h0);
		wr(cisq_pkg::OFF_PFB, 32'h0);
	endtask
	task automatic t_group();
		wr(cisq_pkg::OFF_PEA, 32'h01);
		wr(cisq_pkg::OFF_CTRL, 32'h80);
		pulse(18'h00100);
		quiet(64);
		wr(cisq_pkg::OFF_CTRL, 32'hc0);
		wait_load(60);
		chk("entry push and vector", 32'h1, {31'h0, push_ok});
		rchk("global enable cleared", cisq_pkg::OFF_CTRL, 32'h40);
		wr_irq(cisq_pkg::OFF_IMSK, 32'h1, 1'b1);
		wr_irq(cisq_pkg::OFF_IMSK, 32'h0, 1'b0);
		wr_irq(cisq_pkg::OFF_IMSK, 32'h1, 1'b1);
		wr_irq(cisq_pkg::OFF_IST, 32'h1, 1'b0);
		wr(cisq_pkg::OFF_PFA, 32'h0);
		retire();
		rchk("global enable restored", cisq_pkg::OFF_CTRL, 32'hc0);
		wr(cisq_pkg::OFF_PEA, 32'h0);
	endtask
	task automatic t_sync();
		wr(cisq_pkg::OFF_CTRL, 32'ha0);
		pulse(18'h20000);
		wait_load(60);
		chk("sync latency", 32'h1, {31'h0, load_at - ev_at >= 17 && load_at - ev_at <= 32});
		chk("flush to vector", 32'd16, load_at - flush_at);
		chk("entry push and vector", 32'h1, {31'h0, push_ok});
		rchk("ctrl in service", cisq_pkg::OFF_CTRL, 32'h24);
		wr(cisq_pkg::OFF_CTRL, 32'h28);
		pulse(18'h10000);
		quiet(64);
		rchk("flag during service", cisq_pkg::OFF_CTRL, 32'h29);
		retire();
		wait_load(60);
		wr(cisq_pkg::OFF_CTRL, 32'h0);
		retire();
	endtask
	task automatic t_pin();
		wr(cisq_pkg::OFF_CTRL, 32'h90);
		pin <= 1'b1;
		wait_load(80);
		chk("pin latency", 32'h1, {31'h0, load_at - pin_at >= 20 && load_at - pin_at <= 51});
		rchk("pin flag rising", cisq_pkg::OFF_CTRL, 32'h12);
		wr(cisq_pkg::OFF_CTRL, 32'h10);
		wr(cisq_pkg::OFF_OPT, 32'h0);
		pin <= 1'b0;
		repeat (20) @(posedge clk);
		rchk("pin flag falling", cisq_pkg::OFF_CTRL, 32'h12);
		wr(cisq_pkg::OFF_CTRL, 32'h10);
		pin <= 1'b1;
		repeat (20) @(posedge clk);
		rchk("no flag on wrong edge", cisq_pkg::OFF_CTRL, 32'h10);
		rchk("status all events", cisq_pkg::OFF_IST, 32'h7);
		wr(cisq_pkg::OFF_IST, 32'h7);
	endtask
	// Verdict and end of run
	task automatic results();
		if (bad_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Main sequence; the second reset lands with every control enable and all of enable A set
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		evt = '0;
		pin = 1'b0;
		ret = 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_quarter();
		t_flags();
		t_group();
		t_sync();
		t_pin();
		wr(cisq_pkg::OFF_CTRL, 32'hf8);
		wr(cisq_pkg::OFF_PEA, 32'hff);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		results();
	end
	// Watchdog well beyond the several hundred cycles the scenarios need
	initial begin
		#50000;
		bad_count++;
		results();
	end
endmodule
`default_nettype wire
